// [rtl/can_power_mode_control.sv]
// Behaviour
// - Listen-only: receive, tx recessive, no transmit start
// - Listen-only: dominant tx bits looped back internally
// - Module disabled stops all controller clocks
// - Sleep stops clocks except register access
// - Wake-up interrupt only in sleep, enabled
// - Power-down on CPU stop, or wait+clock-stop
// - Power-down: stop, abort, tx recessive, block regs
// - Leaving wait power-down restarts into normal, or returns to sleep or init
// - Power-down without sleep or init adds recovery delay
// - Sleep waits until all tx buffers empty
// - Sleep after receive ends, else after sync
// - Sleep acknowledge set once sleep is active
// - Bus-off count paused in sleep, tx recessive
// - Sleep: no receive shift, no aborts
// - Wake-up disabled: rx held recessive in sleep
// - Leave sleep by bus activity or cleared request
// - After wake, wait eleven recessive bits
// - Pending actions resume after wake-up
// - Init entry: abort, tx recessive, halt core
// - Init resets registers, unlocks configuration
// - Init request synchronised, acknowledge when done
// - Clearing init request ignored until acknowledged
// - Optional low-pass filter on wake-up input
//
// Added by the designer: the Wishbone register port and the register addresses.
module can_power_mode_control
  import can_pm_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // CPU power state
  input wire logic cpu_stop_i,
  input wire logic cpu_wait_i,
  // Protocol layer
  input wire logic tx_pending_i,
  input wire logic bus_idle_i,
  input wire logic proto_tx_bit_i,
  input wire logic bit_tick_i,
  output logic proto_rx_bit_o,
  output logic tx_start_allow_o,
  output logic rx_shift_allow_o,
  output logic abort_allow_o,
  output logic abort_o,
  output logic busoff_count_en_o,
  output logic core_clk_en_o,
  output logic regs_default_o,
  output logic config_unlock_o,
  output logic wakeup_irq_o,
  // Bus pins
  input wire logic bus_rx_pin_i,
  output logic bus_tx_pin_o
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    mode_t mode;
    logic ack;
    logic [31:0] rdata;
    logic init_req;
    logic sleep_req;
    logic wakeup_function_enable;
    logic wakeup_irq_enable;
    logic clock_stop_in_wait;
    logic enable;
    logic listen;
    logic wakeup_filter_select;
    logic init_ack;
    logic sleep_ack;
    logic wake_flag;
    logic was_sleep;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] flt;
    logic rx_meta;
    logic rx_sync;
    logic tx_pin;
    logic rx_int;
    logic tx_allow;
    logic rx_shift;
    logic abort_ok;
    logic abort;
    logic regs_def;
    logic unlock;
    logic clk_en;
    logic busoff_en;
    logic irq;
  } state_t;

  state_t q;
  state_t d;

  wb_req_t req;
  proto_in_t pin;
  cpu_state_t cpu;

  assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i,
                 adr: adr_i, dat: dat_i};
  assign pin = '{tx_pending: tx_pending_i, bus_idle: bus_idle_i,
                 proto_tx_bit: proto_tx_bit_i, bit_tick: bit_tick_i};
  assign cpu = '{cpu_stop: cpu_stop_i, cpu_wait: cpu_wait_i};

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic pd_cond;
    logic wr;
    logic rd;
    logic activity;
    logic running;
    logic filt_hit;
    pd_cond = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    activity = 1'b0;
    running = 1'b0;
    filt_hit = 1'b0;
    d = q;
    d.abort = 1'b0;

    // Pin synchroniser; only the second stage is used below
    d.rx_meta = bus_rx_pin_i;
    d.rx_sync = q.rx_meta;

    pd_cond = q.enable && (cpu.cpu_stop ||
              (cpu.cpu_wait && q.clock_stop_in_wait));

    // Wake-up detector, filter needs a long dominant run
    if (q.rx_sync) begin
      d.flt = '0;
    end else if (q.flt != {CNT_W{1'b1}}) begin
      d.flt = q.flt + 1'b1;
    end
    filt_hit = !q.wakeup_filter_select ||
               (q.flt >= CNT_W'(WAKE_FILTER_CYC - 1));
    activity = q.wakeup_function_enable && !q.rx_sync &&
               filt_hit;

    // Register access, blocked while powered down
    d.ack = req.cyc && req.stb && !q.ack;
    wr = d.ack && req.we && req.sel[0] &&
         (q.mode != M_POWERDOWN);
    rd = d.ack && !req.we;
    if (wr && req.adr == CTRL0_OFS) begin
      if (req.dat[C0_INIT_REQ] || q.init_ack) begin
        d.init_req = req.dat[C0_INIT_REQ];
      end
      if (req.dat[C0_SLEEP_REQ] || q.sleep_ack) begin
        d.sleep_req = req.dat[C0_SLEEP_REQ];
      end
      d.wakeup_function_enable = req.dat[C0_WAKEUP_FUNCTION_ENABLE];
      d.wakeup_irq_enable = req.dat[C0_WAKEUP_IRQ_ENABLE];
      d.clock_stop_in_wait = req.dat[C0_CLOCK_STOP_IN_WAIT];
    end
    if (wr && req.adr == CTRL1_OFS && q.init_ack) begin
      d.wakeup_filter_select = req.dat[C1_WAKEUP_FILTER_SELECT];
      d.listen = req.dat[C1_LISTEN];
      d.enable = req.dat[C1_ENABLE];
    end
    // Clear comes first, so a same-cycle wake-up set wins
    if (wr && req.adr == STATUS_OFS && req.dat[ST_WAKE_FLAG]) begin
      d.wake_flag = 1'b0;
    end
    if (rd) begin
      d.rdata = '0;
      if (q.mode != M_POWERDOWN) begin
        unique case (req.adr)
          CTRL0_OFS: begin
            d.rdata[C0_INIT_REQ] = q.init_req;
            d.rdata[C0_SLEEP_REQ] = q.sleep_req;
            d.rdata[C0_WAKEUP_FUNCTION_ENABLE] = q.wakeup_function_enable;
            d.rdata[C0_WAKEUP_IRQ_ENABLE] = q.wakeup_irq_enable;
            d.rdata[C0_CLOCK_STOP_IN_WAIT] = q.clock_stop_in_wait;
          end
          STATUS_OFS: begin
            d.rdata[ST_INIT_ACK] = q.init_ack;
            d.rdata[ST_SLEEP_ACK] = q.sleep_ack;
            d.rdata[ST_WAKE_FLAG] = q.wake_flag;
            d.rdata[ST_RESYNC] = (q.mode == M_RESYNC);
            d.rdata[ST_RECOVER] = (q.mode == M_RECOVER);
          end
          CTRL1_OFS: begin
            d.rdata[C1_WAKEUP_FILTER_SELECT] = q.wakeup_filter_select;
            d.rdata[C1_LISTEN] = q.listen;
            d.rdata[C1_ENABLE] = q.enable;
          end
          default: begin
            d.rdata = '0;
          end
        endcase
      end
    end

    if (q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
    end

    // Mode sequencing, power-down first, then init
    if (pd_cond && q.mode != M_POWERDOWN) begin
      d.was_sleep = (q.mode == M_SLEEP);
      d.mode = M_POWERDOWN;
      d.abort = 1'b1;
    end else if (q.init_req && !q.init_ack &&
                 q.mode != M_INIT_SYNC && q.mode != M_POWERDOWN) begin
      d.mode = M_INIT_SYNC;
      d.cnt = CNT_W'(INIT_SYNC_CYC - 1);
      d.abort = 1'b1;
      d.sleep_ack = 1'b0;
    end else begin
      unique case (q.mode)
        M_NORMAL: begin
          if (q.sleep_req) begin
            d.mode = M_SLEEP_PEND;
            d.cnt = CNT_W'(SYNC_DELAY_CYC - 1);
          end
        end
        M_SLEEP_PEND: begin
          // A frame still being received holds off until idle
          if (q.cnt == '0 && !pin.tx_pending &&
              pin.bus_idle) begin
            d.mode = M_SLEEP;
            d.sleep_ack = 1'b1;
          end
        end
        M_SLEEP: begin
          if (!q.sleep_req) begin
            d.mode = M_RESYNC;
            d.sleep_ack = 1'b0;
            d.cnt = CNT_W'(RESYNC_BITS);
          end else if (activity) begin
            d.mode = M_RESYNC;
            d.sleep_req = 1'b0;
            d.sleep_ack = 1'b0;
            d.wake_flag = 1'b1;
            d.cnt = CNT_W'(RESYNC_BITS);
          end
        end
        M_INIT_SYNC: begin
          d.sleep_req = 1'b0;
          d.wakeup_function_enable = 1'b0;
          d.wakeup_irq_enable = 1'b0;
          d.wake_flag = 1'b0;
          if (q.cnt == '0) begin
            d.mode = M_INIT;
            d.init_ack = 1'b1;
          end
        end
        M_INIT: begin
          if (!q.init_req) begin
            d.init_ack = 1'b0;
            d.mode = M_RESYNC;
            d.cnt = CNT_W'(RESYNC_BITS);
          end
        end
        M_POWERDOWN: begin
          if (q.was_sleep && activity) begin
            d.mode = M_RESYNC;
            d.sleep_req = 1'b0;
            d.sleep_ack = 1'b0;
            d.wake_flag = 1'b1;
            d.cnt = CNT_W'(RESYNC_BITS);
          end else if (!pd_cond) begin
            if (q.was_sleep) begin
              d.mode = M_SLEEP;
            end else if (q.init_ack) begin
              d.mode = M_INIT;
            end else begin
              d.mode = M_RECOVER;
              d.cnt = CNT_W'(RECOVERY_CYC - 1);
            end
          end
        end
        M_RECOVER: begin
          if (q.cnt == '0) begin
            d.mode = M_NORMAL;
          end
        end
        M_RESYNC: begin
          // Dominant restarts the run, so the waking frame is lost
          if (!q.rx_sync) begin
            d.cnt = CNT_W'(RESYNC_BITS);
          end else if (pin.bit_tick) begin
            if (q.cnt <= CNT_W'(1)) begin
              d.mode = M_NORMAL;
              d.cnt = '0;
            end else begin
              d.cnt = q.cnt - 1'b1;
            end
          end else begin
            d.cnt = q.cnt;
          end
        end
        default: begin
          d.mode = M_NORMAL;
        end
      endcase
    end

    // Registered outputs, computed from the next mode
    running = d.enable && (d.mode == M_NORMAL ||
              d.mode == M_SLEEP_PEND || d.mode == M_RESYNC);
    d.clk_en = d.enable && (running ||
               d.mode == M_RECOVER);
    d.tx_allow = running && (d.mode != M_RESYNC) &&
                 !d.listen;
    d.tx_pin = (d.tx_allow || (running && d.mode != M_RESYNC &&
                !d.listen)) ? pin.proto_tx_bit
                            : 1'b1;
    if (d.listen || d.mode == M_RESYNC) begin
      d.tx_pin = 1'b1;
    end
    if (d.mode == M_SLEEP && !d.wakeup_function_enable) begin
      d.rx_int = 1'b1;
    end else if (d.listen) begin
      d.rx_int = q.rx_sync && pin.proto_tx_bit;
    end else begin
      d.rx_int = q.rx_sync;
    end
    d.rx_shift = running;
    d.abort_ok = running;
    d.busoff_en = running;
    d.regs_def = (d.mode == M_INIT_SYNC ||
                  d.mode == M_INIT);
    d.unlock = d.init_ack;
    d.irq = d.wake_flag && d.wakeup_irq_enable;
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.mode <= M_INIT;
      q.init_req <= RST_INIT_REQ;
      q.init_ack <= RST_INIT_ACK;
      q.enable <= RST_ENABLE;
      q.unlock <= RST_INIT_ACK;
      q.regs_def <= 1'b1;
      q.tx_pin <= 1'b1;
      q.rx_int <= 1'b1;
      q.rx_meta <= 1'b1;
      q.rx_sync <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign dat_o = q.rdata;
  assign ack_o = q.ack;
  assign proto_rx_bit_o = q.rx_int;
  assign tx_start_allow_o = q.tx_allow;
  assign rx_shift_allow_o = q.rx_shift;
  assign abort_allow_o = q.abort_ok;
  assign abort_o = q.abort;
  assign busoff_count_en_o = q.busoff_en;
  assign core_clk_en_o = q.clk_en;
  assign regs_default_o = q.regs_def;
  assign config_unlock_o = q.unlock;
  assign wakeup_irq_o = q.irq;
  assign bus_tx_pin_o = q.tx_pin;

endmodule : can_power_mode_control

// [include/can_pm_pkg.sv]
package can_pm_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int SYNC_DELAY_NS = 150;
  localparam int RECOVERY_NS = 1000;
  localparam int WAKE_FILTER_NS = 2000;
  localparam int SYNC_DELAY_CYC =
    (SYNC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVERY_CYC =
    (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_FILTER_CYC =
    (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Two bus clocks plus three controller clocks, one clock here
  localparam int INIT_SYNC_CYC = 2 + 3;
  localparam int RESYNC_BITS = 11;
  localparam int CNT_W = 16;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL0_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] CTRL1_OFS = 8'h08;

  // Control 0 fields
  localparam int C0_INIT_REQ = 0;
  localparam int C0_SLEEP_REQ = 1;
  localparam int C0_WAKEUP_FUNCTION_ENABLE = 2;
  localparam int C0_WAKEUP_IRQ_ENABLE = 3;
  localparam int C0_CLOCK_STOP_IN_WAIT = 5;
  // Status fields
  localparam int ST_INIT_ACK = 0;
  localparam int ST_SLEEP_ACK = 1;
  localparam int ST_WAKE_FLAG = 2;
  localparam int ST_RESYNC = 3;
  localparam int ST_RECOVER = 4;
  // Control 1 fields
  localparam int C1_WAKEUP_FILTER_SELECT = 2;
  localparam int C1_LISTEN = 4;
  localparam int C1_ENABLE = 7;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic RST_INIT_REQ = 1'b1;
  localparam logic RST_INIT_ACK = 1'b1;
  localparam logic RST_ENABLE = 1'b0;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [7:0] {
    M_NORMAL = 8'h01,
    M_SLEEP_PEND = 8'h02,
    M_SLEEP = 8'h04,
    M_INIT_SYNC = 8'h08,
    M_INIT = 8'h10,
    M_POWERDOWN = 8'h20,
    M_RECOVER = 8'h40,
    M_RESYNC = 8'h80
  } mode_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic tx_pending;
    logic bus_idle;
    logic proto_tx_bit;
    logic bit_tick;
  } proto_in_t;

  typedef struct packed {
    logic cpu_stop;
    logic cpu_wait;
  } cpu_state_t;

endpackage : can_pm_pkg

// [tb/can_bus_node.sv]
module can_bus_node (
  // Control from bench
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] len_i,
  // Bus level, 1 is recessive
  output logic bus_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_q = 8'h00;
  // Dominant for len_i cycles, then released to recessive idle
  always @(posedge clk_i) begin
    if (go_i) begin
      cnt_q <= len_i;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  assign bus_o = (cnt_q == 8'h00);
endmodule : can_bus_node

// [tb/can_power_mode_control_checker.sv]
module can_power_mode_control_checker (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic cpu_stop_i,
  input wire logic abort_o,
  input wire logic bus_tx_pin_o,
  input wire logic core_clk_en_o,
  input wire logic tx_start_allow_o,
  input wire logic regs_default_o,
  input wire logic config_unlock_o,
  input wire logic busoff_count_en_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_ack_req;
    cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("no ack");
  property p_ack_one;
    ack_o |=> !ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("long ack");
  property p_abort_one;
    abort_o |=> !abort_o;
  endproperty
  a_abort_one: assert property (p_abort_one) else $error("abort");
  property p_halt_tx;
    regs_default_o |-> bus_tx_pin_o && !tx_start_allow_o;
  endproperty
  a_halt_tx: assert property (p_halt_tx) else $error("init tx");
  // Unlock not earlier than four cycles after regs_default_o rises, then within twenty more
  property p_init_delay;
    $rose(regs_default_o) |-> !config_unlock_o[*4] ##[1:20]
      config_unlock_o;
  endproperty
  a_init_delay: assert property (p_init_delay) else $error("init");
  property p_stop_clk;
    cpu_stop_i [*2] |=> !core_clk_en_o;
  endproperty
  a_stop_clk: assert property (p_stop_clk) else $error("stop");
  property p_pd_entry;
    core_clk_en_o && tx_start_allow_o && cpu_stop_i |=>
      abort_o && bus_tx_pin_o && !core_clk_en_o;
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("pd");
  property p_busoff;
    busoff_count_en_o |-> core_clk_en_o;
  endproperty
  a_busoff: assert property (p_busoff) else $error("busoff");
endmodule : can_power_mode_control_checker

bind can_power_mode_control can_power_mode_control_checker
  u_can_power_mode_control_checker (.clk_i, .rst_i, .cyc_i, .stb_i,
  .ack_o, .cpu_stop_i, .abort_o, .bus_tx_pin_o, .core_clk_en_o,
  .tx_start_allow_o, .regs_default_o, .config_unlock_o,
  .busoff_count_en_o);

// [tb/can_power_mode_control_tb.sv]
module can_power_mode_control_tb
  import can_pm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
  logic we_i = 1'b0, cpu_stop_i = 1'b0, cpu_wait_i = 1'b0, go = 1'b0;
  logic tx_pending_i = 1'b0, bus_idle_i = 1'b1, proto_tx_bit_i = 1'b1;
  logic bit_tick_i = 1'b0, bus_rx_pin_i, bus_tx_pin_o, ack_o;
  logic [3:0] sel_i = 4'hF;
  logic [7:0] adr_i = 8'h00, len = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o;
  logic proto_rx_bit_o, tx_start_allow_o, rx_shift_allow_o;
  logic abort_allow_o, abort_o, busoff_count_en_o, core_clk_en_o;
  logic regs_default_o, config_unlock_o, wakeup_irq_o;
  int mismatches = 0, samples_checked = 0;
  always #25 clk_i = ~clk_i;
  can_power_mode_control u_can_power_mode_control (.clk_i, .rst_i,
    .cyc_i, .stb_i, .we_i, .sel_i, .adr_i, .dat_i, .dat_o, .ack_o,
    .cpu_stop_i, .cpu_wait_i, .tx_pending_i, .bus_idle_i,
    .proto_tx_bit_i, .bit_tick_i, .proto_rx_bit_o, .tx_start_allow_o,
    .rx_shift_allow_o, .abort_allow_o, .abort_o, .busoff_count_en_o,
    .core_clk_en_o, .regs_default_o, .config_unlock_o, .wakeup_irq_o,
    .bus_rx_pin_i, .bus_tx_pin_o);
  can_bus_node u_can_bus_node (.clk_i, .go_i(go), .len_i(len),
    .bus_o(bus_rx_pin_i));
  // -----
  // Tasks
  // -----
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string s, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s exp %h got %h", s, e, g);
    end
  endtask : chk
  // Master holds the request until ack is sampled, bounded wait
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      wrap_up();
    end
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input string s, input logic [7:0] a,
                    input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(s, e, q);
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_i);
      bit_tick_i <= 1'b1;
      @(posedge clk_i);
      bit_tick_i <= 1'b0;
    end
  endtask : tick
  task automatic dom(input logic [7:0] n);
    @(posedge clk_i);
    go <= 1'b1;
    len <= n;
    @(posedge clk_i);
    go <= 1'b0;
  endtask : dom
  // ---------
  // Scenarios
  // ---------
  task automatic t_start();
    rd("status", STATUS_OFS, 32'h01);
    chk("unlock", 1, config_unlock_o);
    chk("clk off", 0, core_clk_en_o);
    wr(CTRL1_OFS, 32'h80);
    wr(CTRL0_OFS, 32'h00);
    tick(10);
    chk("tx early", 0, tx_start_allow_o);
    tick(1);
    wt(2);
    chk("tx allow", 1, tx_start_allow_o);
    $display("start done");
  endtask : t_start
  task automatic t_power();
    // Dominant request, so a forced recessive pin is visible
    cpu_wait_i <= 1'b1;
    proto_tx_bit_i <= 1'b0;
    wt(4);
    chk("wait clk", 1, core_clk_en_o);
    chk("run pin", 0, bus_tx_pin_o);
    wr(CTRL0_OFS, 32'h20);
    wt(4);
    chk("pd clk", 0, core_clk_en_o);
    chk("pd pin", 1, bus_tx_pin_o);
    rd("pd read", CTRL0_OFS, 32'h0);
    cpu_wait_i <= 1'b0;
    rd("recover", STATUS_OFS, 32'h10);
    wt(25);
    chk("normal", 1, tx_start_allow_o);
    cpu_stop_i <= 1'b1;
    wt(4);
    chk("stop clk", 0, core_clk_en_o);
    cpu_stop_i <= 1'b0;
    proto_tx_bit_i <= 1'b1;
    wt(25);
    $display("power done");
  endtask : t_power
  task automatic t_sleep();
    tx_pending_i <= 1'b1;
    bus_idle_i <= 1'b0;
    wr(CTRL0_OFS, 32'h0E);
    wt(10);
    rd("tx busy", STATUS_OFS, 32'h0);
    tx_pending_i <= 1'b0;
    wt(10);
    rd("rx busy", STATUS_OFS, 32'h0);
    bus_idle_i <= 1'b1;
    wt(6);
    rd("asleep", STATUS_OFS, 32'h02);
    chk("sl clk", 0, core_clk_en_o);
    chk("sl shift", 0, rx_shift_allow_o);
    chk("sl abort", 0, abort_allow_o);
    chk("sl boff", 0, busoff_count_en_o);
    chk("sl irq", 0, wakeup_irq_o);
    dom(8'h0A);
    wt(8);
    rd("woken", STATUS_OFS, 32'h0C);
    chk("irq", 1, wakeup_irq_o);
    wr(STATUS_OFS, 32'h04);
    wt(2);
    chk("irq clr", 0, wakeup_irq_o);
    tick(11);
    wt(2);
    chk("tx", 1, tx_start_allow_o);
    chk("shift", 1, rx_shift_allow_o);
    chk("abort", 1, abort_allow_o);
    $display("sleep done");
  endtask : t_sleep
  task automatic t_lock();
    wr(CTRL0_OFS, 32'h02);
    wt(8);
    dom(8'h0A);
    wt(8);
    chk("lk rx", 1, proto_rx_bit_o);
    rd("locked", STATUS_OFS, 32'h02);
    wr(CTRL0_OFS, 32'h00);
    wt(2);
    rd("left", STATUS_OFS, 32'h08);
    tick(11);
    $display("lock done");
  endtask : t_lock
  task automatic t_init();
    wr(CTRL0_OFS, 32'h01);
    wr(CTRL0_OFS, 32'h00);
    wt(8);
    rd("init ack", STATUS_OFS, 32'h01);
    chk("regs def", 1, regs_default_o);
    chk("unlock", 1, config_unlock_o);
    wr(CTRL1_OFS, 32'h94);
    wr(CTRL0_OFS, 32'h00);
    tick(11);
    wt(2);
    rd("resync", STATUS_OFS, 32'h0);
    proto_tx_bit_i <= 1'b0;
    wt(3);
    chk("lo pin", 1, bus_tx_pin_o);
    chk("lo loop", 0, proto_rx_bit_o);
    chk("lo start", 0, tx_start_allow_o);
    proto_tx_bit_i <= 1'b1;
    wr(CTRL0_OFS, 32'h06);
    wt(6);
    // Short pulse must be over before looking, or it merges
    dom(8'h14);
    wt(30);
    rd("glitch", STATUS_OFS, 32'h02);
    dom(8'h3C);
    wt(70);
    rd("filt wake", STATUS_OFS, 32'h0C);
    $display("init done");
  endtask : t_init
  initial begin
    wt(6);
    rst_i <= 1'b0;
    t_start();
    t_power();
    t_sleep();
    t_lock();
    t_init();
    wrap_up();
  end
endmodule : can_power_mode_control_tb
